// ### design/core_local_interrupt_unit.sv
// Core-local interrupt unit: trigger, timer, pending, cause and trap timing.
// Assumes the hart supplies its enables and clears the global enable on
// entry to a handler; register port is single-cycle word access.
// Operation
// (R1) Pending status shows software at bit 3, timer at 7, external at 11.
// (R2) An interrupt trap sets cause bit 31 and the interrupt number below.
// (R3) An exception trap clears cause bit 31 and records its code below.
// (R4) Cause holds the code in 9:0, zero in 30:10, interrupt flag in 31.
// (R5) Exception codes 0 to 8 and 11 are defined, the rest reserved.
// (R6) External is taken before software, and software before timer.
// (R7) The handler fetch is issued 3 cycles after the interrupt is taken.
// (R8) External requests pass 3 extra cycles before becoming pending.
// (R9) The trigger register keeps bit 0 only; upper 31 bits read zero.
// (R10) The trigger register clears on reset.
// (R11) A 64-bit count register, software writable, counts slow ticks.
// (R12) Timer pending is high while count is at or above compare.
// (R13) Reset clears the count and leaves compare untouched.
// (R14) An interrupt is taken only with global and own enable both set.
// (R15) The slow tick is synchronised and each rising edge adds one.
`timescale 1ns/100ps
module core_local_interrupt_unit (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic rtc_tick,
    input wire core_local_interruptor_pkg::bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    output logic bus_rvalid,
    input wire logic ext_irq_in,
    input wire logic glb_irq_enable,
    input wire logic [31:0] irq_enable,
    input wire logic exc_valid,
    input wire logic [9:0] exc_code,
    input wire logic cause_wr,
    input wire logic [31:0] cause_wdata,
    output logic [31:0] irq_pending_status,
    output logic [31:0] trap_cause,
    output core_local_interruptor_pkg::trap_evt_t trap_evt,
    output logic timer_irq_pending
);

    logic tick_rise;
    logic [31:0] soft_irq_trigger_r;
    logic [31:0] soft_irq_trigger_nxt;
    logic [63:0] timer_count_r;
    logic [63:0] timer_count_nxt;
    logic [63:0] timer_compare_r;
    logic [63:0] timer_compare_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [2:0] ext_pipe_r;
    logic [2:0] ext_pipe_nxt;
    logic [31:0] cause_r;
    logic [31:0] cause_nxt;
    core_local_interruptor_pkg::trap_state_t state_r;
    core_local_interruptor_pkg::trap_state_t state_nxt;
    logic [2:0] lat_r;
    logic [2:0] lat_nxt;
    logic take_r;
    logic take_nxt;
    logic fetch_r;
    logic fetch_nxt;
    logic is_irq_r;
    logic is_irq_nxt;
    logic [9:0] code_r;
    logic [9:0] code_nxt;
    logic [31:0] pend;
    logic ext_pend;
    logic soft_pend;
    logic timer_pend;

    function automatic logic hit(input core_local_interruptor_pkg::bus_req_t r,
                                 input logic [27:0] a);
        hit = (r.addr == a);
    endfunction : hit

    function automatic logic exc_legal(input logic [9:0] c);
        exc_legal = (c <= core_local_interruptor_pkg::EXC_ECALL_U) ||
                    (c == core_local_interruptor_pkg::EXC_ECALL_M);
    endfunction : exc_legal

    // ********************************************************
    // Tick crossing
    // ********************************************************
    tick_sync u_tick_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .tick_in(rtc_tick),
        .tick_rise(tick_rise)
    );

    // ********************************************************
    // Register port and timer
    // ********************************************************
    always_comb
    begin
        soft_irq_trigger_nxt = soft_irq_trigger_r;
        timer_compare_nxt = timer_compare_r;
        timer_count_nxt = timer_count_r;
        // (R15) count each tick edge
        if (tick_rise)
        begin
            timer_count_nxt = timer_count_r + 64'h0000000000000001;
        end
        rdata_nxt = 32'h00000000;
        rvalid_nxt = bus_req.rd;
        if (bus_req.wr)
        begin
            // (R9) keep bit 0 only
            if (hit(bus_req, core_local_interruptor_pkg::SOFT_TRIG_ADDR))
            begin
                soft_irq_trigger_nxt = {31'h00000000, bus_req.wdata[0]};
            end
            if (hit(bus_req, core_local_interruptor_pkg::CMP_LO_ADDR))
            begin
                timer_compare_nxt[31:0] = bus_req.wdata;
            end
            if (hit(bus_req, core_local_interruptor_pkg::CMP_HI_ADDR))
            begin
                timer_compare_nxt[63:32] = bus_req.wdata;
            end
            // (R11) software writes count
            if (hit(bus_req, core_local_interruptor_pkg::CNT_LO_ADDR))
            begin
                timer_count_nxt[31:0] = bus_req.wdata;
            end
            if (hit(bus_req, core_local_interruptor_pkg::CNT_HI_ADDR))
            begin
                timer_count_nxt[63:32] = bus_req.wdata;
            end
        end
        if (bus_req.rd)
        begin
            if (hit(bus_req, core_local_interruptor_pkg::SOFT_TRIG_ADDR))
            begin
                rdata_nxt = soft_irq_trigger_r;
            end
            else if (hit(bus_req, core_local_interruptor_pkg::CMP_LO_ADDR))
            begin
                rdata_nxt = timer_compare_r[31:0];
            end
            else if (hit(bus_req, core_local_interruptor_pkg::CMP_HI_ADDR))
            begin
                rdata_nxt = timer_compare_r[63:32];
            end
            else if (hit(bus_req, core_local_interruptor_pkg::CNT_LO_ADDR))
            begin
                rdata_nxt = timer_count_r[31:0];
            end
            else if (hit(bus_req, core_local_interruptor_pkg::CNT_HI_ADDR))
            begin
                rdata_nxt = timer_count_r[63:32];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        // (R13) compare has no reset
        timer_compare_r <= timer_compare_nxt;
        if (reset)
        begin
            // (R10) trigger clears
            soft_irq_trigger_r <= core_local_interruptor_pkg::SOFT_TRIG_RST;
            // (R13) count clears
            timer_count_r <= core_local_interruptor_pkg::COUNT_RST;
            rdata_r <= 32'h00000000;
            rvalid_r <= 1'b0;
        end
        else
        begin
            soft_irq_trigger_r <= soft_irq_trigger_nxt;
            timer_count_r <= timer_count_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign bus_rdata = rdata_r;
    assign bus_rvalid = rvalid_r;

    // ********************************************************
    // Pending status
    // ********************************************************
    // (R12) count at or above compare
    assign timer_pend = (timer_count_r >= timer_compare_r);
    assign soft_pend = soft_irq_trigger_r[0];
    // (R8) three-cycle global path
    assign ext_pend = ext_pipe_r[2];

    always_comb
    begin
        ext_pipe_nxt = {ext_pipe_r[1:0], ext_irq_in};
        // (R1) fixed bit positions
        pend = 32'h00000000;
        pend[core_local_interruptor_pkg::SOFT_BIT] = soft_pend;
        pend[core_local_interruptor_pkg::TIMER_BIT] = timer_pend;
        pend[core_local_interruptor_pkg::EXT_BIT] = ext_pend;
    end

    assign irq_pending_status = pend;
    assign timer_irq_pending = timer_pend;

    // ********************************************************
    // Trap selection, cause and latency
    // ********************************************************
    always_comb
    begin
        state_nxt = state_r;
        lat_nxt = lat_r;
        take_nxt = 1'b0;
        fetch_nxt = 1'b0;
        is_irq_nxt = is_irq_r;
        code_nxt = code_r;
        cause_nxt = cause_r;
        if (cause_wr)
        begin
            // (R4) reserved field stays zero
            cause_nxt = {cause_wdata[core_local_interruptor_pkg::CAUSE_IRQ_BIT], 21'h000000,
                         cause_wdata[core_local_interruptor_pkg::CODE_W-1:0]};
        end
        unique case (state_r)
            core_local_interruptor_pkg::ST_IDLE:
            begin
                // (R5) legal exception codes
                if (exc_valid && exc_legal(exc_code))
                begin
                    // (R3) exception cause
                    cause_nxt = {1'b0, 21'h000000, exc_code};
                    take_nxt = 1'b1;
                    is_irq_nxt = 1'b0;
                    code_nxt = exc_code;
                    lat_nxt = 3'h1;
                    state_nxt = core_local_interruptor_pkg::ST_WAIT;
                end
                // (R14) global and own enable
                else if (glb_irq_enable && |(pend & irq_enable))
                begin
                    // (R6) external, software, timer
                    if (pend[core_local_interruptor_pkg::EXT_BIT] &&
                        irq_enable[core_local_interruptor_pkg::EXT_BIT])
                    begin
                        code_nxt = core_local_interruptor_pkg::CODE_EXT;
                    end
                    else if (pend[core_local_interruptor_pkg::SOFT_BIT] &&
                             irq_enable[core_local_interruptor_pkg::SOFT_BIT])
                    begin
                        code_nxt = core_local_interruptor_pkg::CODE_SOFT;
                    end
                    else
                    begin
                        code_nxt = core_local_interruptor_pkg::CODE_TIMER;
                    end
                    // (R2) interrupt cause
                    cause_nxt = {1'b1, 21'h000000, code_nxt};
                    take_nxt = 1'b1;
                    is_irq_nxt = 1'b1;
                    lat_nxt = 3'h1;
                    state_nxt = core_local_interruptor_pkg::ST_WAIT;
                end
            end
            core_local_interruptor_pkg::ST_WAIT:
            begin
                // (R7) fetch after fixed latency
                if (lat_r == 3'(core_local_interruptor_pkg::LOCAL_LAT_CYC - 1))
                begin
                    fetch_nxt = 1'b1;
                    state_nxt = core_local_interruptor_pkg::ST_IDLE;
                end
                else
                begin
                    lat_nxt = lat_r + 3'h1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            ext_pipe_r <= 3'h0;
            state_r <= core_local_interruptor_pkg::ST_IDLE;
            lat_r <= 3'h0;
            take_r <= 1'b0;
            fetch_r <= 1'b0;
            is_irq_r <= 1'b0;
            code_r <= 10'h000;
            cause_r <= core_local_interruptor_pkg::CAUSE_RST;
        end
        else
        begin
            ext_pipe_r <= ext_pipe_nxt;
            state_r <= state_nxt;
            lat_r <= lat_nxt;
            take_r <= take_nxt;
            fetch_r <= fetch_nxt;
            is_irq_r <= is_irq_nxt;
            code_r <= code_nxt;
            cause_r <= cause_nxt;
        end
    end

    assign trap_cause = cause_r;
    assign trap_evt.take = take_r;
    assign trap_evt.is_irq = is_irq_r;
    assign trap_evt.code = code_r;
    assign trap_evt.fetch = fetch_r;

endmodule : core_local_interrupt_unit

// ### design/core_local_interruptor_pkg.sv
// Package of constants and carrier types for the core-local interrupt unit.
// Assumes a single hart and 32-bit word accesses on the register port.
package core_local_interruptor_pkg;

    // ********************************************************
    // Register map (byte addresses)
    // ********************************************************
    localparam logic [27:0] SOFT_TRIG_ADDR = 28'h2000000;
    localparam logic [27:0] CMP_LO_ADDR = 28'h2004000;
    localparam logic [27:0] CMP_HI_ADDR = 28'h2004004;
    localparam logic [27:0] CNT_LO_ADDR = 28'h200BFF8;
    localparam logic [27:0] CNT_HI_ADDR = 28'h200BFFC;

    // ********************************************************
    // Pending and enable bit positions
    // ********************************************************
    localparam int SOFT_BIT = 3;
    localparam int TIMER_BIT = 7;
    localparam int EXT_BIT = 11;

    // ********************************************************
    // Cause register layout and codes
    // ********************************************************
    localparam int CAUSE_IRQ_BIT = 31;
    localparam int CODE_W = 10;
    localparam logic [9:0] CODE_SOFT = 10'h003;
    localparam logic [9:0] CODE_TIMER = 10'h007;
    localparam logic [9:0] CODE_EXT = 10'h00B;
    localparam logic [9:0] EXC_FETCH_MISAL = 10'h000;
    localparam logic [9:0] EXC_FETCH_FAULT = 10'h001;
    localparam logic [9:0] EXC_ILLEGAL = 10'h002;
    localparam logic [9:0] EXC_BREAK = 10'h003;
    localparam logic [9:0] EXC_LOAD_MISAL = 10'h004;
    localparam logic [9:0] EXC_LOAD_FAULT = 10'h005;
    localparam logic [9:0] EXC_STORE_MISAL = 10'h006;
    localparam logic [9:0] EXC_STORE_FAULT = 10'h007;
    localparam logic [9:0] EXC_ECALL_U = 10'h008;
    localparam logic [9:0] EXC_ECALL_M = 10'h00B;

    // ********************************************************
    // Reset values and latency counts
    // ********************************************************
    localparam logic [31:0] SOFT_TRIG_RST = 32'h00000000;
    localparam logic [63:0] COUNT_RST = 64'h0000000000000000;
    localparam logic [31:0] CAUSE_RST = 32'h00000000;
    localparam int LOCAL_LAT_CYC = 4;
    localparam int GLOBAL_LAT_CYC = 3;

    // ********************************************************
    // Carrier types
    // ********************************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [27:0] addr;
        logic [31:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic take;
        logic is_irq;
        logic [9:0] code;
        logic fetch;
    } trap_evt_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT
    } trap_state_t;

endpackage : core_local_interruptor_pkg

// ### design/tick_sync.sv
// Synchroniser and rising-edge detector for the slow timer tick.
// Assumes the tick is much slower than the core clock.
`timescale 1ns/100ps
module tick_sync (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic tick_in,
    output logic tick_rise
);

    logic meta_r;
    logic sync_r;
    logic prev_r;

    // ********************************************************
    // Two-flop crossing and edge detect
    // ********************************************************
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            meta_r <= tick_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign tick_rise = sync_r & ~prev_r;

endmodule : tick_sync

// ### sim/core_local_interruptor_chk.sv
// Checker for the core-local interrupt unit, bound to its top ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
module irq_unit_chk (
    input wire logic ref_clk,
    input wire logic reset,
    input wire core_local_interruptor_pkg::bus_req_t bus_req,
    input wire logic ext_irq_in,
    input wire logic glb_irq_enable,
    input wire logic [31:0] irq_enable,
    input wire logic [31:0] irq_pending_status,
    input wire logic [31:0] trap_cause,
    input wire core_local_interruptor_pkg::trap_evt_t trap_evt,
    input wire logic timer_irq_pending
);
    // ********************************************************
    // Port relations
    // ********************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    pend_map_a: assert property (
        (irq_pending_status & 32'hFFFFF777) == 32'h0)
        else $error("pending status reserved bit set");
    irq_cause_a: assert property (
        trap_evt.take && trap_evt.is_irq
        |-> trap_cause == {1'h1, 21'h0, trap_evt.code})
        else $error("interrupt cause wrong");
    exc_cause_a: assert property (
        trap_evt.take && !trap_evt.is_irq
        |-> trap_cause == {1'h0, 21'h0, trap_evt.code})
        else $error("exception cause wrong");
    cause_resv_a: assert property (
        trap_cause[30:10] == 21'h0)
        else $error("cause reserved bits set");
    exc_code_a: assert property (
        trap_evt.take && !trap_evt.is_irq
        |-> trap_evt.code inside {[10'h000:10'h008], 10'h00B})
        else $error("reserved exception code taken");
    ext_first_a: assert property (
        trap_evt.take && trap_evt.is_irq
        && $past(irq_pending_status[11] && irq_enable[11])
        |-> trap_evt.code == 10'h00B)
        else $error("external not taken first");
    fetch_lat_a: assert property (
        trap_evt.take |-> (!trap_evt.fetch) [*3] ##1 trap_evt.fetch)
        else $error("handler fetch not on time");
    ext_lat_a: assert property (
        !$past(reset, 3) && !$past(reset, 2) && !$past(reset)
        |-> irq_pending_status[11] == $past(ext_irq_in, 3))
        else $error("external pending not three cycles late");
    soft_trig_a: assert property (
        bus_req.wr && bus_req.addr == core_local_interruptor_pkg::SOFT_TRIG_ADDR
        |=> irq_pending_status[3] == $past(bus_req.wdata[0]))
        else $error("software pending does not follow trigger");
    soft_rst_a: assert property (
        $fell(reset) |-> !irq_pending_status[3] && !trap_evt.take)
        else $error("trigger not cleared by reset");
    tmr_pend_a: assert property (
        timer_irq_pending |-> irq_pending_status[7])
        else $error("timer pending not shown");
    enable_a: assert property (
        trap_evt.take && trap_evt.is_irq |-> $past(glb_irq_enable)
        && ($past(irq_enable) & (32'h1 << trap_evt.code)) != 32'h0)
        else $error("interrupt taken while disabled");
endmodule : irq_unit_chk

bind core_local_interrupt_unit irq_unit_chk irq_unit_chk_inst (
    .ref_clk(ref_clk), .reset(reset), .bus_req(bus_req),
    .ext_irq_in(ext_irq_in), .glb_irq_enable(glb_irq_enable),
    .irq_enable(irq_enable), .irq_pending_status(irq_pending_status),
    .trap_cause(trap_cause), .trap_evt(trap_evt),
    .timer_irq_pending(timer_irq_pending)
);

// ### sim/hart_model.sv
// Model of the hart trap side: global enable and handler fetch timing.
// Assumes the bench pulses ret_req to leave a handler.
`timescale 1ns/100ps
module hart_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire core_local_interruptor_pkg::trap_evt_t trap_evt,
    input wire logic ret_req,
    output logic glb_irq_enable,
    output logic [3:0] gap_r
);
    logic [3:0] cnt_r;
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            glb_irq_enable <= 1'h0;
            cnt_r <= 4'h0;
            gap_r <= 4'h0;
        end
        else
        begin
            if (trap_evt.take)
                glb_irq_enable <= 1'h0;
            else if (ret_req)
                glb_irq_enable <= 1'h1;
            if (trap_evt.take)
                cnt_r <= 4'h1;
            else if (trap_evt.fetch)
                cnt_r <= 4'h0;
            else if (cnt_r != 4'h0)
                cnt_r <= cnt_r + 4'h1;
            if (trap_evt.fetch)
                gap_r <= cnt_r;
        end
    end
endmodule : hart_model

// ### sim/core_local_interrupt_unit_tb_top.sv
// Testbench for the core-local interrupt unit with a hart model.
// Assumes inputs change at falling edges of the 125 MHz clock.
`timescale 1ns/100ps
module core_local_interrupt_unit_tb_top;
    logic ref_clk, reset, rtc_tick, rvalid, ext_irq_in, exc_valid;
    logic cause_wr, tpend, glb, ret_req;
    logic [31:0] rdata, irq_enable, cause_wdata, pend, cause, exp_c;
    logic [9:0] exc_code;
    logic [3:0] gap;
    core_local_interruptor_pkg::bus_req_t req;
    core_local_interruptor_pkg::trap_evt_t evt;
    int failures = 0;
    int tests_run = 0;

    core_local_interrupt_unit core_local_interrupt_unit_inst (
        .ref_clk(ref_clk), .reset(reset), .rtc_tick(rtc_tick),
        .bus_req(req), .bus_rdata(rdata), .bus_rvalid(rvalid),
        .ext_irq_in(ext_irq_in), .glb_irq_enable(glb),
        .irq_enable(irq_enable), .exc_valid(exc_valid),
        .exc_code(exc_code), .cause_wr(cause_wr),
        .cause_wdata(cause_wdata), .irq_pending_status(pend),
        .trap_cause(cause), .trap_evt(evt), .timer_irq_pending(tpend)
    );
    hart_model hart_model_inst (
        .ref_clk(ref_clk), .reset(reset), .trap_evt(evt),
        .ret_req(ret_req), .glb_irq_enable(glb), .gap_r(gap)
    );

    // ********************************************************
    // Tasks
    // ********************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [27:0] a, input logic [31:0] d);
        @(negedge ref_clk);
        req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(negedge ref_clk);
        req.wr = 1'h0;
    endtask : wr
    task automatic rd(input logic [27:0] a, input logic [31:0] exp);
        @(negedge ref_clk);
        req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 32'h0};
        @(negedge ref_clk);
        req.rd = 1'h0;
        chk(32'(rvalid), 32'h1);
        chk(rdata, exp);
    endtask : rd
    task automatic tick(input int n);
        repeat (n)
        begin
            @(negedge ref_clk);
            rtc_tick = 1'h1;
            repeat (3) @(negedge ref_clk);
            rtc_tick = 1'h0;
            repeat (3) @(negedge ref_clk);
        end
    endtask : tick
    task automatic trap(input logic [31:0] exp);
        int n = 0;
        @(negedge ref_clk);
        ret_req = 1'h1;
        @(negedge ref_clk);
        ret_req = 1'h0;
        while (evt.take !== 1'h1 && n < 20)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk(32'(evt.take), 32'h1);
        chk(cause, exp);
        repeat (5) @(negedge ref_clk);
        chk(32'(gap), 32'(core_local_interruptor_pkg::LOCAL_LAT_CYC - 1));
    endtask : trap
    task automatic do_reset();
        reset = 1'h1;
        repeat (12) @(negedge ref_clk);
        reset = 1'h0;
    endtask : do_reset
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        give_verdict();
    end

    // ********************************************************
    // Tests
    // ********************************************************
    initial
    begin
        {rtc_tick, ext_irq_in, exc_valid, cause_wr, ret_req} = 5'h0;
        req = '0;
        irq_enable = 32'h0;
        cause_wdata = 32'h0;
        exc_code = 10'h0;
        do_reset();
        rd(core_local_interruptor_pkg::SOFT_TRIG_ADDR, 32'h0);
        rd(core_local_interruptor_pkg::CNT_LO_ADDR, 32'h0);
        rd(core_local_interruptor_pkg::CNT_HI_ADDR, 32'h0);
        rd(28'h2000004, 32'h0);
        chk(cause, 32'h0);
        $display("test reset done");
        wr(core_local_interruptor_pkg::SOFT_TRIG_ADDR, 32'hFFFFFFFF);
        rd(core_local_interruptor_pkg::SOFT_TRIG_ADDR, 32'h1);
        chk(pend & 32'hFFFFFF7F, 32'h8);
        wr(core_local_interruptor_pkg::SOFT_TRIG_ADDR, 32'h0);
        chk(pend & 32'hFFFFFF7F, 32'h0);
        $display("test trigger done");
        wr(core_local_interruptor_pkg::CNT_HI_ADDR, 32'h2);
        wr(core_local_interruptor_pkg::CNT_LO_ADDR, 32'h10);
        rd(core_local_interruptor_pkg::CNT_HI_ADDR, 32'h2);
        tick(5);
        rd(core_local_interruptor_pkg::CNT_LO_ADDR, 32'h15);
        $display("test count done");
        wr(core_local_interruptor_pkg::CMP_HI_ADDR, 32'h2);
        wr(core_local_interruptor_pkg::CMP_LO_ADDR, 32'h17);
        chk(32'(tpend), 32'h0);
        tick(2);
        chk(pend, 32'h80);
        wr(core_local_interruptor_pkg::CNT_HI_ADDR, 32'h1);
        chk(32'(tpend), 32'h0);
        do_reset();
        rd(core_local_interruptor_pkg::CNT_LO_ADDR, 32'h0);
        rd(core_local_interruptor_pkg::CMP_LO_ADDR, 32'h17);
        $display("test compare done");
        exp_c = cause;
        for (int c = 0; c < 13; c++)
        begin
            if (!(c inside {9, 10, 12}))
                exp_c = 32'(c);
            @(negedge ref_clk);
            exc_valid = 1'h1;
            exc_code = 10'(c);
            @(negedge ref_clk);
            exc_valid = 1'h0;
            chk(cause, exp_c);
            repeat (4) @(negedge ref_clk);
        end
        $display("test exceptions done");
        irq_enable = 32'h888;
        ext_irq_in = 1'h1;
        wr(core_local_interruptor_pkg::CNT_HI_ADDR, 32'h3);
        wr(core_local_interruptor_pkg::SOFT_TRIG_ADDR, 32'h1);
        trap(32'h8000000B);
        ext_irq_in = 1'h0;
        repeat (4) @(negedge ref_clk);
        trap(32'h80000003);
        wr(core_local_interruptor_pkg::SOFT_TRIG_ADDR, 32'h0);
        trap(32'h80000007);
        cause_wr = 1'h1;
        cause_wdata = 32'hFFFFFFFF;
        @(negedge ref_clk);
        cause_wr = 1'h0;
        chk(cause, 32'h800003FF);
        irq_enable = 32'h800;
        ret_req = 1'h1;
        @(negedge ref_clk);
        ret_req = 1'h0;
        repeat (8) @(negedge ref_clk);
        chk(cause, 32'h800003FF);
        $display("test interrupts done");
        give_verdict();
    end
endmodule : core_local_interrupt_unit_tb_top
